//--- upr_link_model.sv
// link controller model issuing register commands
// assumes commands launched on the falling edge, answers registered
`timescale 1ns/1ps
module upr_link_model
  import upr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  input wire logic dir_in,
  output upr_cmd_s cmd_out
);
  initial cmd_out = '0;
  // idle address and data inverted so a stale value never passes
  task automatic issue(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    cmd_out <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge clk_sys_in);
    cmd_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : issue
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    int n;
    issue(1'b0, a, 8'h00);
    n = 0;
    while (rvalid_in !== 1'b1 && n < 4) begin
      @(negedge clk_sys_in);
      n++;
    end
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
  endtask : rd_reg
  // link stays off the bus until dir drops
  task automatic wait_dir_low(output int cyc);
    cyc = 0;
    while (dir_in !== 1'b0 && cyc < 50) begin
      @(negedge clk_sys_in);
      cyc++;
    end
  endtask : wait_dir_low
endmodule : upr_link_model

//--- upr_pkg.sv
// register map, field layouts, reset values and timing counts of the ulpi register bank
// assumes a single 40 MHz clock shared by every user of this package
package upr_pkg;

  // clock and transceiver reset timing
  localparam int UPR_CLK_PERIOD_NS = 25;
  localparam int UPR_CORE_RST_NS = 200;
  localparam int UPR_CORE_RST_CYC =
    (UPR_CORE_RST_NS + UPR_CLK_PERIOD_NS - 1) / UPR_CLK_PERIOD_NS;

  // register addresses, six bits wide
  localparam logic [5:0] UPR_ADDR_FUNC = 6'h04;
  localparam logic [5:0] UPR_ADDR_IFACE = 6'h07;
  localparam logic [5:0] UPR_ADDR_LINE = 6'h15;
  localparam logic [5:0] UPR_ADDR_SCRATCH = 6'h16;
  localparam logic [5:0] UPR_ADDR_ROUTE = 6'h19;
  localparam logic [5:0] UPR_ADDR_DRIVE = 6'h31;
  localparam logic [5:0] UPR_OFS_SET = 6'h01;
  localparam logic [5:0] UPR_OFS_CLR = 6'h02;

  // writable bits of each register, and the readable bits of the read-only line register
  localparam logic [7:0] UPR_MASK_FUNC = 8'h7F;
  localparam logic [7:0] UPR_MASK_IFACE = 8'h84;
  localparam logic [7:0] UPR_MASK_SCRATCH = 8'hFF;
  localparam logic [7:0] UPR_MASK_ROUTE = 8'h0C;
  localparam logic [7:0] UPR_MASK_DRIVE = 8'h07;
  localparam logic [7:0] UPR_MASK_LINE = 8'h03;

  // reset values
  localparam logic [7:0] UPR_RST_FUNC = 8'h41;
  localparam logic [7:0] UPR_RST_IFACE = 8'h00;
  localparam logic [7:0] UPR_RST_SCRATCH = 8'h00;
  localparam logic [7:0] UPR_RST_ROUTE = 8'h00;
  localparam logic [7:0] UPR_RST_DRIVE = 8'h00;
  localparam logic [7:0] UPR_UNMAPPED_READ = 8'h00;

  // field positions
  localparam int UPR_IFACE_PASS_BIT = 2;
  localparam int UPR_IFACE_PROT_OFF_BIT = 7;
  localparam int UPR_ROUTE_TX_BIT = 2;
  localparam int UPR_ROUTE_RX_BIT = 3;
  localparam int UPR_DRIVE_EDGE_BIT = 2;

  // speed and encoding codes
  localparam logic [1:0] UPR_SPEED_HS = 2'h0;
  localparam logic [1:0] UPR_SPEED_FS = 2'h1;
  localparam logic [1:0] UPR_SPEED_LS = 2'h3;
  localparam logic [1:0] UPR_ENC_NORMAL = 2'h0;
  localparam logic [1:0] UPR_ENC_NON_DRIVING = 2'h1;
  localparam logic [1:0] UPR_ENC_NO_STUFF = 2'h2;
  localparam logic [1:0] UPR_ENC_NO_SYNC_EOP = 2'h3;

  // transceiver function setup layout
  typedef struct packed {
    logic reserved;
    logic low_power_n;
    logic xcvr_reset;
    logic [1:0] transmit_encoding_mode;
    logic termination_select;
    logic [1:0] transceiver_speed_select;
  } upr_func_s;

  // register command from the ulpi front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } upr_cmd_s;

  typedef enum logic [1:0] {UPR_ACC_NONE, UPR_ACC_WRITE, UPR_ACC_SET, UPR_ACC_CLEAR} upr_acc_e;

endpackage : upr_pkg

//--- upr_reg_bank.sv
// ulpi transceiver control and status register bank with transceiver reset sequencer
// assumes a ulpi front end that decodes tx cmd bytes into one-cycle register commands
// What this block does
// - speed field selects hs 00, fs 01, fs for ls packets 11; 10 reserved.
// - termination select bit drives pull-up and hs termination control.
// - encoding mode bits 4:3 select normal, non-driving, or no stuffing/nrzi.
// - encoding mode 11 suppresses automatic sync and eop, hs packets only.
// - link setting transceiver reset bit raises dir and resets the core.
// - after core reset, dir drops and the reset bit clears itself.
// - after dir drops, dir rises again carrying an rx cmd update.
// - transceiver reset leaves interface logic and registers unchanged.
// - writing zero to low power bit enters low power mode.
// - leaving low power mode sets the low power bit back to one.
// - interface bit 2 switches interface into serial pass-through mode.
// - device clears pass-through bit when uart pass-through ends.
// - interface bit 7 zero enables bus protection; one disables its pulls.
// - read-only line register shows live line bits at 0 and 1, rest zero.
// - eight-bit scratch register, readable, writable, settable, clearable.
// - set/clear registers read at base to base+2, write base, set +1, clear +2.
// - routing bits act only while pass-through mode is set.
// - routing bit 2 sends data line 0 to the dm pin.
// - routing bit 3 sends dp pin to data line 1.
// - drive field selects full, three-quarter, half, quarter strength.
// - drive bit 2 selects slow edge rate at 0, fast at 1.
// - registers use a six-bit address carried in the tx cmd byte.
`timescale 1ns/1ps
module upr_reg_bank
  import upr_pkg::*;
#(
  parameter int CORE_RST_CYCLES = UPR_CORE_RST_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic wake_in,
  input wire logic uart_exit_in,
  input wire logic line_level_bit0_in,
  input wire logic line_level_bit1_in,
  input wire logic dp_in,
  input wire logic data0_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [1:0] transceiver_speed_select_out,
  output logic termination_select_out,
  output logic [1:0] transmit_encoding_mode_out,
  output logic non_driving_out,
  output logic bit_stuff_off_out,
  output logic auto_sync_eop_off_out,
  output logic low_power_out,
  output logic serial_pass_through_mode_out,
  output logic protect_en_out,
  output logic pass_tx_route_out,
  output logic pass_rx_route_out,
  output logic dm_pass_out,
  output logic data1_pass_out,
  output logic [1:0] output_drive_level_out,
  output logic output_edge_rate_out,
  output logic dir_out,
  output logic core_rst_out,
  output logic rx_cmd_valid_out,
  output logic [7:0] rx_cmd_out
);

  initial begin
    if (CORE_RST_CYCLES < 1 || CORE_RST_CYCLES > 65535) begin
      $error("core reset cycles out of range");
    end
  end

  typedef enum {UPR_ST_IDLE, UPR_ST_CORE, UPR_ST_GAP, UPR_ST_NOTIFY} upr_state_e;

  upr_cmd_s cmd;
  upr_func_s func_reg;
  upr_func_s next_func_reg;
  logic [7:0] iface_reg;
  logic [7:0] next_iface_reg;
  logic [7:0] scratch_reg;
  logic [7:0] next_scratch_reg;
  logic [7:0] route_reg;
  logic [7:0] next_route_reg;
  logic [7:0] drive_reg;
  logic [7:0] next_drive_reg;
  logic [3:0] pins_sync;
  logic [1:0] line_sync;
  upr_state_e state;
  upr_state_e next_state;
  logic [15:0] rst_cnt;
  logic [15:0] next_rst_cnt;
  logic bus_free;
  logic acc_wr;
  logic acc_rd;
  upr_acc_e acc_func;
  upr_acc_e acc_iface;
  upr_acc_e acc_scratch;
  upr_acc_e acc_route;
  upr_acc_e acc_drive;
  logic rst_done;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_dir;
  logic next_core_rst;
  logic next_rx_cmd_valid;
  logic [7:0] next_rx_cmd;
  logic pass_mode;
  logic tx_route;
  logic rx_route;

  assign cmd = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

  // pin inputs: line bits, dp and ulpi data line 0
  upr_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .async_in({data0_in, dp_in, line_level_bit1_in, line_level_bit0_in}),
    .sync_out(pins_sync)
  );
  assign line_sync = pins_sync[1:0];

  // accesses during the reset sequence are dropped; the link may not drive then
  assign bus_free = (state == UPR_ST_IDLE);
  assign acc_wr = cmd.wr && bus_free;
  assign acc_rd = cmd.rd && bus_free;

  // six-bit address decode to write, set or clear
  function automatic upr_acc_e decode_acc(
    input logic [5:0] addr,
    input logic [5:0] base,
    input logic has_set_clr
  );
    upr_acc_e kind;
    kind = UPR_ACC_NONE;
    if (addr == base) begin
      kind = UPR_ACC_WRITE;
    end else if (has_set_clr && addr == base + UPR_OFS_SET) begin
      kind = UPR_ACC_SET;
    end else if (has_set_clr && addr == base + UPR_OFS_CLR) begin
      kind = UPR_ACC_CLEAR;
    end
    return kind;
  endfunction : decode_acc

  // reserved bits are masked so they hold their zero reset value
  function automatic logic [7:0] apply_acc(
    input logic [7:0] old,
    input logic [7:0] wdata,
    input upr_acc_e kind,
    input logic [7:0] mask
  );
    logic [7:0] res;
    res = old;
    case (kind)
      UPR_ACC_WRITE: res = wdata;
      UPR_ACC_SET: res = old | wdata;
      UPR_ACC_CLEAR: res = old & ~wdata;
      default: res = old;
    endcase
    return res & mask;
  endfunction : apply_acc

  always_comb begin
    acc_func = UPR_ACC_NONE;
    acc_iface = UPR_ACC_NONE;
    acc_scratch = UPR_ACC_NONE;
    acc_route = UPR_ACC_NONE;
    acc_drive = UPR_ACC_NONE;
    if (acc_wr) begin
      acc_func = decode_acc(cmd.addr, UPR_ADDR_FUNC, 1'b1);
      acc_iface = decode_acc(cmd.addr, UPR_ADDR_IFACE, 1'b1);
      acc_scratch = decode_acc(cmd.addr, UPR_ADDR_SCRATCH, 1'b1);
      acc_route = decode_acc(cmd.addr, UPR_ADDR_ROUTE, 1'b1);
      acc_drive = decode_acc(cmd.addr, UPR_ADDR_DRIVE, 1'b0);
    end
  end

  // register file
  always_comb begin
    next_func_reg = upr_func_s'(apply_acc(func_reg, cmd.wdata, acc_func, UPR_MASK_FUNC));
    next_iface_reg = apply_acc(iface_reg, cmd.wdata, acc_iface, UPR_MASK_IFACE);
    next_scratch_reg = apply_acc(scratch_reg, cmd.wdata, acc_scratch, UPR_MASK_SCRATCH);
    next_route_reg = apply_acc(route_reg, cmd.wdata, acc_route, UPR_MASK_ROUTE);
    next_drive_reg = apply_acc(drive_reg, cmd.wdata, acc_drive, UPR_MASK_DRIVE);
    // self clear at the end of the core reset; no write can land then
    if (rst_done) begin
      next_func_reg.xcvr_reset = 1'b0;
    end
    // wake applied last so it wins over a clear in the same cycle
    if (wake_in) begin
      next_func_reg.low_power_n = 1'b1;
    end
    // a write in the same cycle as the exit takes effect
    if (uart_exit_in && acc_iface == UPR_ACC_NONE) begin
      next_iface_reg[UPR_IFACE_PASS_BIT] = 1'b0;
    end
  end

  // only rst_n_in resets the registers; the core reset leaves them alone
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      func_reg <= upr_func_s'(UPR_RST_FUNC);
      iface_reg <= UPR_RST_IFACE;
      scratch_reg <= UPR_RST_SCRATCH;
      route_reg <= UPR_RST_ROUTE;
      drive_reg <= UPR_RST_DRIVE;
    end else begin
      func_reg <= next_func_reg;
      iface_reg <= next_iface_reg;
      scratch_reg <= next_scratch_reg;
      route_reg <= next_route_reg;
      drive_reg <= next_drive_reg;
    end
  end

  // read path, answer one cycle after the command
  always_comb begin
    next_rvalid = acc_rd;
    next_rdata = UPR_UNMAPPED_READ;
    if (!acc_rd) begin
      next_rdata = UPR_UNMAPPED_READ;
    end else if (cmd.addr >= UPR_ADDR_FUNC && cmd.addr <= UPR_ADDR_FUNC + UPR_OFS_CLR) begin
      next_rdata = func_reg & UPR_MASK_FUNC;
    end else if (cmd.addr >= UPR_ADDR_IFACE && cmd.addr <= UPR_ADDR_IFACE + UPR_OFS_CLR) begin
      next_rdata = iface_reg;
    end else if (cmd.addr == UPR_ADDR_LINE) begin
      next_rdata = {6'h00, line_sync} & UPR_MASK_LINE;
    end else if (cmd.addr >= UPR_ADDR_SCRATCH && cmd.addr <= UPR_ADDR_SCRATCH + UPR_OFS_CLR) begin
      next_rdata = scratch_reg;
    end else if (cmd.addr >= UPR_ADDR_ROUTE && cmd.addr <= UPR_ADDR_ROUTE + UPR_OFS_CLR) begin
      next_rdata = route_reg;
    end else if (cmd.addr == UPR_ADDR_DRIVE) begin
      next_rdata = drive_reg;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rdata_out <= next_rdata;
      reg_rvalid_out <= next_rvalid;
    end
  end

  // transceiver reset sequencer: dir high, core reset, one cycle low, rx cmd
  assign rst_done = (state == UPR_ST_CORE) && (rst_cnt == 16'h0001);

  always_comb begin
    next_state = state;
    next_rst_cnt = rst_cnt;
    next_dir = 1'b0;
    next_core_rst = 1'b0;
    next_rx_cmd_valid = 1'b0;
    next_rx_cmd = rx_cmd_out;
    case (state)
      UPR_ST_IDLE: begin
        if (func_reg.xcvr_reset) begin
          next_state = UPR_ST_CORE;
          next_rst_cnt = 16'(CORE_RST_CYCLES);
          next_dir = 1'b1;
          next_core_rst = 1'b1;
        end
      end
      UPR_ST_CORE: begin
        if (rst_done) begin
          next_state = UPR_ST_GAP;
          next_rst_cnt = 16'h0000;
        end else begin
          next_rst_cnt = rst_cnt - 16'h0001;
          next_dir = 1'b1;
          next_core_rst = 1'b1;
        end
      end
      UPR_ST_GAP: begin
        // line state carried in the low bits of the rx cmd update
        next_state = UPR_ST_NOTIFY;
        next_dir = 1'b1;
        next_rx_cmd_valid = 1'b1;
        next_rx_cmd = {6'h00, line_sync};
      end
      UPR_ST_NOTIFY: begin
        next_state = UPR_ST_IDLE;
      end
      default: begin
        next_state = UPR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state <= UPR_ST_IDLE;
      rst_cnt <= 16'h0000;
      dir_out <= 1'b0;
      core_rst_out <= 1'b0;
      rx_cmd_valid_out <= 1'b0;
      rx_cmd_out <= 8'h00;
    end else begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
      dir_out <= next_dir;
      core_rst_out <= next_core_rst;
      rx_cmd_valid_out <= next_rx_cmd_valid;
      rx_cmd_out <= next_rx_cmd;
    end
  end

  // control outputs, registered one cycle behind the register file
  assign pass_mode = iface_reg[UPR_IFACE_PASS_BIT];
  assign tx_route = pass_mode && route_reg[UPR_ROUTE_TX_BIT];
  assign rx_route = pass_mode && route_reg[UPR_ROUTE_RX_BIT];

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      transceiver_speed_select_out <= UPR_SPEED_FS;
      termination_select_out <= 1'b0;
      transmit_encoding_mode_out <= UPR_ENC_NORMAL;
      non_driving_out <= 1'b0;
      bit_stuff_off_out <= 1'b0;
      auto_sync_eop_off_out <= 1'b0;
      low_power_out <= 1'b0;
      serial_pass_through_mode_out <= 1'b0;
      protect_en_out <= 1'b1;
      pass_tx_route_out <= 1'b0;
      pass_rx_route_out <= 1'b0;
      dm_pass_out <= 1'b0;
      data1_pass_out <= 1'b0;
      output_drive_level_out <= 2'h0;
      output_edge_rate_out <= 1'b0;
    end else begin
      transceiver_speed_select_out <= func_reg.transceiver_speed_select;
      termination_select_out <= func_reg.termination_select;
      transmit_encoding_mode_out <= func_reg.transmit_encoding_mode;
      non_driving_out <= func_reg.transmit_encoding_mode == UPR_ENC_NON_DRIVING;
      bit_stuff_off_out <= func_reg.transmit_encoding_mode == UPR_ENC_NO_STUFF;
      // only honoured at high speed
      auto_sync_eop_off_out <= (func_reg.transmit_encoding_mode == UPR_ENC_NO_SYNC_EOP)
        && (func_reg.transceiver_speed_select == UPR_SPEED_HS);
      low_power_out <= !func_reg.low_power_n;
      serial_pass_through_mode_out <= pass_mode;
      protect_en_out <= !iface_reg[UPR_IFACE_PROT_OFF_BIT];
      pass_tx_route_out <= tx_route;
      pass_rx_route_out <= rx_route;
      dm_pass_out <= tx_route && pins_sync[3];
      data1_pass_out <= rx_route && pins_sync[2];
      output_drive_level_out <= drive_reg[1:0];
      output_edge_rate_out <= drive_reg[UPR_DRIVE_EDGE_BIT];
    end
  end

endmodule : upr_reg_bank

//--- upr_reg_bank_chk.sv
// concurrent checks on the register bank ports
// assumes binding into upr_reg_bank, one clock, sync active-low reset
`timescale 1ns/1ps
module upr_reg_bank_chk
  import upr_pkg::*;
#(
  parameter int CORE_RST_CYCLES = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic dir_out,
  input wire logic core_rst_out,
  input wire logic rx_cmd_valid_out,
  input wire logic [7:0] rx_cmd_out,
  input wire logic [1:0] transceiver_speed_select_out,
  input wire logic [1:0] transmit_encoding_mode_out,
  input wire logic non_driving_out,
  input wire logic bit_stuff_off_out,
  input wire logic auto_sync_eop_off_out,
  input wire logic serial_pass_through_mode_out,
  input wire logic pass_tx_route_out,
  input wire logic pass_rx_route_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // counts core reset cycles; repetition cannot take a parameter
  logic [7:0] hold_cnt;
  logic [7:0] next_hold_cnt;
  always_comb begin
    next_hold_cnt = core_rst_out ? hold_cnt + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in)
      hold_cnt <= 8'h00;
    else
      hold_cnt <= next_hold_cnt;
  end
  sequence seq_rx_update;
    !dir_out ##1 (dir_out && rx_cmd_valid_out) ##1 (!dir_out && !rx_cmd_valid_out);
  endsequence
  chk_dir_in_reset: assert property (core_rst_out |-> dir_out)
    else $error("dir low while core held in reset");
  chk_reset_length: assert property ($fell(core_rst_out) |-> hold_cnt == 8'(CORE_RST_CYCLES))
    else $error("core reset length wrong");
  chk_rx_after_reset: assert property ($fell(core_rst_out) |-> seq_rx_update)
    else $error("rx cmd update missing after core reset");
  chk_rx_cmd_byte: assert property (rx_cmd_valid_out |-> dir_out && rx_cmd_out[7:2] == 6'h00)
    else $error("rx cmd byte without dir or with upper bits set");
  chk_read_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read answer without read command");
  chk_rdata_quiet: assert property (!reg_rvalid_out |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside answer");
  chk_no_sync_hs: assert property (auto_sync_eop_off_out ==
    (transmit_encoding_mode_out == 2'h3 && transceiver_speed_select_out == 2'h0))
    else $error("sync and eop suppression wrong");
  chk_enc_decode: assert property ((non_driving_out == (transmit_encoding_mode_out == 2'h1))
    && (bit_stuff_off_out == (transmit_encoding_mode_out == 2'h2)))
    else $error("encoding mode decode wrong");
  chk_route_gate: assert property ((pass_tx_route_out || pass_rx_route_out)
    |-> serial_pass_through_mode_out)
    else $error("route active outside pass-through mode");
endmodule : upr_reg_bank_chk

//--- upr_reg_bank_test.sv
// self-checking bench for the register bank
// assumes upr_link_model drives commands, bench drives pins on falling edge
`timescale 1ns/1ps
module upr_reg_bank_test import upr_pkg::*; ;
  localparam int NRST = 3;
  logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, wake_in, uart_exit_in, dp_in, data0_in;
  logic line_level_bit0_in, line_level_bit1_in, reg_rvalid_out, non_driving_out;
  logic [5:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, rx_cmd_out, v;
  logic [1:0] transceiver_speed_select_out, transmit_encoding_mode_out, output_drive_level_out;
  logic termination_select_out, bit_stuff_off_out, auto_sync_eop_off_out, low_power_out;
  logic serial_pass_through_mode_out, protect_en_out, pass_tx_route_out, pass_rx_route_out;
  logic dm_pass_out, data1_pass_out, output_edge_rate_out, dir_out, core_rst_out, rx_cmd_valid_out;
  upr_cmd_s cmd;
  int fail_count, checks, n;
  logic [5:0] ra [12] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h15, 6'h16, 6'h19,
    6'h31, 6'h20, 6'h3F};
  logic [7:0] rv [12] = '{8'h41, 8'h41, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  upr_reg_bank #(.CORE_RST_CYCLES(NRST)) uut (.*);
  upr_link_model link (.clk_sys_in(clk_sys_in), .rvalid_in(reg_rvalid_out),
    .rdata_in(reg_rdata_out), .dir_in(dir_out), .cmd_out(cmd));
  assign {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = cmd;
  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_byte
  task automatic cmp_pin(input string nm, input logic [1:0] e, input logic [1:0] g);
    cmp_byte(nm, {6'h00, e}, {6'h00, g});
  endtask : cmp_pin
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_byte(nm, {7'h00, e}, {7'h00, g});
  endtask : cmp_bit
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    link.issue(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    link.rd_reg(a, v);
    cmp_byte($sformatf("reg %h", a), e, v);
  endtask : rd_chk
  // outputs trail the register by one flop
  task automatic settle;
    repeat (3) @(negedge clk_sys_in);
  endtask : settle
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (4000) @(posedge clk_sys_in);
    fail_count++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    {rst_n_in, wake_in, uart_exit_in, dp_in, data0_in} = '0;
    {line_level_bit0_in, line_level_bit1_in} = '0;
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    cmp_pin("speed at reset", 2'h1, transceiver_speed_select_out);
    cmp_bit("protect at reset", 1'b1, protect_en_out);
    cmp_bit("term at reset", 1'b0, termination_select_out);
    for (n = 0; n < 12; n++) rd_chk(ra[n], rv[n]);
    $display("test reset values done");
    wr(6'h16, 8'hA5);
    wr(6'h17, 8'h0A);
    wr(6'h18, 8'h05);
    for (n = 0; n < 3; n++) rd_chk(6'h16 + n[5:0], 8'hAA);
    $display("test scratch done");
    wr(6'h07, 8'hFF);
    wr(6'h19, 8'hFF);
    wr(6'h15, 8'hFF);
    rd_chk(6'h07, 8'h84);
    rd_chk(6'h1A, 8'h0C);
    rd_chk(6'h15, 8'h00);
    {data0_in, dp_in} = 2'h3;
    repeat (8) @(negedge clk_sys_in);
    cmp_bit("protect off", 1'b0, protect_en_out);
    cmp_bit("pass mode", 1'b1, serial_pass_through_mode_out);
    cmp_bit("dm pass", 1'b1, dm_pass_out);
    cmp_bit("data1 pass", 1'b1, data1_pass_out);
    cmp_bit("tx route", 1'b1, pass_tx_route_out);
    cmp_bit("rx route", 1'b1, pass_rx_route_out);
    uart_exit_in = 1'b1;
    @(negedge clk_sys_in);
    uart_exit_in = 1'b0;
    settle();
    rd_chk(6'h09, 8'h80);
    cmp_bit("tx route gated", 1'b0, pass_tx_route_out);
    cmp_bit("dm gated", 1'b0, dm_pass_out);
    cmp_bit("rx route gated", 1'b0, pass_rx_route_out);
    cmp_bit("data1 gated", 1'b0, data1_pass_out);
    $display("test pass-through done");
    for (n = 0; n < 4; n++) begin
      wr(6'h31, {5'h1F, n[0], n[1:0]});
      settle();
      rd_chk(6'h31, {5'h00, n[0], n[1:0]});
      cmp_pin("drive level", n[1:0], output_drive_level_out);
      cmp_bit("edge rate", n[0], output_edge_rate_out);
    end
    $display("test drive done");
    for (n = 0; n < 16; n++) begin
      if (n[1:0] != 2'h2) begin
        wr(6'h04, {3'h6, n[3:2], 1'b1, n[1:0]});
        settle();
        cmp_pin("speed", n[1:0], transceiver_speed_select_out);
        cmp_pin("encoding", n[3:2], transmit_encoding_mode_out);
        cmp_bit("no sync eop", n == 12, auto_sync_eop_off_out);
        cmp_bit("termination", 1'b1, termination_select_out);
        cmp_bit("non driving", n[3:2] == 2'h1, non_driving_out);
        cmp_bit("no stuff", n[3:2] == 2'h2, bit_stuff_off_out);
      end
    end
    $display("test function fields done");
    wr(6'h06, 8'h5A);
    settle();
    cmp_bit("low power", 1'b1, low_power_out);
    wake_in = 1'b1;
    @(negedge clk_sys_in);
    wake_in = 1'b0;
    settle();
    rd_chk(6'h06, 8'h45);
    cmp_bit("low power left", 1'b0, low_power_out);
    $display("test low power done");
    {line_level_bit1_in, line_level_bit0_in} = 2'h2;
    repeat (8) @(negedge clk_sys_in);
    rd_chk(6'h15, 8'h02);
    wr(6'h05, 8'h20);
    n = 0;
    while (dir_out !== 1'b1 && n < 10) begin
      @(negedge clk_sys_in);
      n++;
    end
    cmp_bit("core reset", 1'b1, core_rst_out);
    link.wait_dir_low(n);
    cmp_byte("core reset cycles", NRST[7:0], n[7:0]);
    @(negedge clk_sys_in);
    cmp_pin("dir and rx valid", 2'h3, {dir_out, rx_cmd_valid_out});
    cmp_byte("rx cmd", 8'h02, rx_cmd_out);
    @(negedge clk_sys_in);
    rd_chk(6'h04, 8'h45);
    rd_chk(6'h16, 8'hAA);
    rd_chk(6'h31, 8'h07);
    rd_chk(6'h07, 8'h80);
    $display("test transceiver reset done");
    report_and_stop();
  end
endmodule : upr_reg_bank_test
bind upr_reg_bank upr_reg_bank_chk #(.CORE_RST_CYCLES(CORE_RST_CYCLES)) chk (.*);

//--- upr_sync.sv
// three-flop synchroniser bank for pin inputs
// assumes inputs are asynchronous to clk_sys_in; output moves when stages two and three agree
`timescale 1ns/1ps
module upr_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("upr_sync width must be at least one");
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic next_out;
      // s1 feeds s2 only, to keep metastability out of the compare
      always_comb begin
        next_out = sync_out[gi];
        if (s2 == s3) begin
          next_out = s3;
        end
      end
      always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          s1 <= async_in[gi];
          s2 <= s1;
          s3 <= s2;
          sync_out[gi] <= next_out;
        end
      end
    end
  endgenerate

endmodule : upr_sync
